// ---- common/blim_cfg.svh ----
`ifndef BLIM_CFG_SVH
`define BLIM_CFG_SVH
`define BLIM_CLK_HZ 100000000
`define BLIM_SCL_HZ 100000
`define BLIM_QTR_CYC (`BLIM_CLK_HZ / (4 * `BLIM_SCL_HZ))
`define BLIM_CODE_HI 16'h3fff
`define BLIM_SCR_LO 16'he000
`define BLIM_SCR_HI 16'he1ff
`define BLIM_EE_DEV_WIDE 7'h51
`define BLIM_EE_DEV_NARROW 7'h50
`define BLIM_SIG_ID_ONLY 8'ha0
`define BLIM_SIG_LOAD 8'ha2
`define BLIM_ID_LAST 3'h6
`define BLIM_HDR_LAST 3'h3
`define BLIM_END_MARK_BIT 7
`define BLIM_CTL_START_BIT 7
`define BLIM_CTL_STOP_BIT 6
`define BLIM_CTL_LAST_BIT 5
`define BLIM_CTL_BUSY_BIT 2
`define BLIM_CTL_ACK_BIT 1
`define BLIM_CTL_DONE_BIT 0
`endif

// ---- common/blim_pkg.sv ----
`include "blim_cfg.svh"
package blim_pkg;
   typedef enum logic [1:0] {CMD_START, CMD_STOP, CMD_WRITE, CMD_READ} blim_cmd_t;
   typedef enum logic [1:0] {E_IDLE = 2'h0, E_START = 2'h1, E_BIT = 2'h3, E_STOP = 2'h2} blim_eng_st_t;
   typedef enum logic [1:0] {END_RETRY, END_FAIL, END_OK} blim_end_t;
   typedef enum logic [3:0] {
      B_IDLE = 4'h0, B_START = 4'h1, B_DEVW = 4'h3, B_AH = 4'h2, B_AL = 4'h6, B_RSTART = 4'h7,
      B_DEVR = 4'h5, B_SIG = 4'h4, B_ID = 4'hc, B_HDR = 4'hd, B_DATA = 4'hf, B_DUMMY = 4'he,
      B_STOP = 4'ha, B_DONE = 4'hb, B_RUN = 4'h9
   } blim_boot_st_t;
   typedef struct packed {
      blim_eng_st_t st;
      logic [15:0] qcnt;
      logic [1:0] ph;
      logic [3:0] bitn;
      logic [8:0] tx;
      logic [8:0] rx;
      logic scl_oe;
      logic sda_oe;
      logic done;
   } blim_eng_state_t;
   typedef struct packed {
      blim_boot_st_t boot_st;
      logic por;
      logic wait_e;
      logic two_b;
      logic load;
      blim_end_t stop_next;
      logic [2:0] cnt;
      logic [55:0] idw;
      logic [15:0] len;
      logic [15:0] addr;
      logic hold;
      logic hprev;
      logic cpu_rst;
      logic cmd_valid;
      blim_cmd_t cmd;
      logic [7:0] tx;
      logic nack;
      logic ram_we;
      logic ram_re;
      logic [15:0] ram_addr;
      logic [7:0] ram_wdata;
      logic [1:0] h_ph;
      logic h_ack;
      logic h_err;
      logic [7:0] h_rdata;
      logic c_start;
      logic c_stop;
      logic c_last;
      logic c_wr;
      logic c_rd;
      logic c_done;
      logic c_ack;
      blim_cmd_t c_op;
      logic [7:0] c_tx;
      logic [7:0] c_rx;
      logic [7:0] ctl_view;
      logic pin_lvl;
      logic boot_done;
   } blim_top_state_t;
   function automatic logic blim_in_ram(input logic [15:0] a);
      return (a <= `BLIM_CODE_HI) || (a >= `BLIM_SCR_LO && a <= `BLIM_SCR_HI);
   endfunction
endpackage

// ---- common/blim_eng_if.sv ----
`timescale 1ns/1ps
interface blim_eng_if;
   logic cmd_valid;
   blim_pkg::blim_cmd_t cmd;
   logic [7:0] tx_byte;
   logic nack;
   logic done;
   logic [7:0] rx_byte;
   logic ack;
   logic busy;
   modport ctrl(output cmd_valid, cmd, tx_byte, nack, input done, rx_byte, ack, busy);
   modport eng(input cmd_valid, cmd, tx_byte, nack, output done, rx_byte, ack, busy);
endinterface

// ---- hw/blim_bit_engine.sv ----
`timescale 1ns/1ps
`include "blim_cfg.svh"
module blim_bit_engine #(
   parameter int QTR_CYC = `BLIM_QTR_CYC
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   blim_eng_if.eng eng,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_oe_out,
   output logic sda_oe_out
);
   import blim_pkg::*;
   if (QTR_CYC < 1 || QTR_CYC > 65535) begin : g_bad_qtr
      $error("QTR_CYC out of range");
   end
   blim_eng_state_t s, s_next;
   logic tick;
   logic stretch;
   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_next = s;
      s_next.done = 1'b0;
      stretch = !s.scl_oe && !scl_in;
      tick = (s.qcnt == 16'(QTR_CYC - 1)) && !stretch;
      if (s.st != E_IDLE && !stretch) begin
         s_next.qcnt = tick ? 16'h0 : s.qcnt + 16'h1;
      end
      if (s.st != E_IDLE && tick) begin
         s_next.ph = s.ph + 2'h1;
      end
      unique case (s.st)
         E_IDLE: begin
            if (eng.cmd_valid) begin
               s_next.ph = 2'h0;
               s_next.qcnt = 16'h0;
               s_next.bitn = 4'h0;
               unique case (eng.cmd)
                  CMD_START: s_next.st = E_START;
                  CMD_STOP: s_next.st = E_STOP;
                  CMD_WRITE: begin
                     s_next.tx = {eng.tx_byte, 1'b1};
                     s_next.st = E_BIT;
                  end
                  CMD_READ: begin
                     s_next.tx = {8'hff, eng.nack};
                     s_next.st = E_BIT;
                  end
               endcase
            end
         end
         E_START: begin
            if (tick) begin
               unique case (s.ph)
                  2'h0: s_next.sda_oe = 1'b0;
                  2'h1: s_next.scl_oe = 1'b0;
                  2'h2: s_next.sda_oe = 1'b1;
                  2'h3: begin
                     s_next.scl_oe = 1'b1;
                     s_next.st = E_IDLE;
                     s_next.done = 1'b1;
                  end
               endcase
            end
         end
         E_BIT: begin
            if (tick) begin
               unique case (s.ph)
                  2'h0: s_next.sda_oe = !s.tx[8];
                  2'h1: s_next.scl_oe = 1'b0;
                  2'h2: s_next.rx = {s.rx[7:0], sda_in};
                  2'h3: begin
                     s_next.scl_oe = 1'b1;
                     s_next.tx = {s.tx[7:0], 1'b1};
                     s_next.bitn = s.bitn + 4'h1;
                     if (s.bitn == 4'h8) begin
                        s_next.st = E_IDLE;
                        s_next.done = 1'b1;
                     end
                  end
               endcase
            end
         end
         E_STOP: begin
            if (tick) begin
               unique case (s.ph)
                  2'h0: s_next.sda_oe = 1'b1;
                  2'h1: s_next.scl_oe = 1'b0;
                  2'h2: s_next.sda_oe = 1'b0;
                  2'h3: begin
                     s_next.st = E_IDLE;
                     s_next.done = 1'b1;
                  end
               endcase
            end
         end
      endcase
      if (!rst_b_in) begin
         s_next = '0;
      end
   end
   always_ff @(posedge clk_in) begin
      s <= s_next;
   end
   ////////////////////////////////////////////////////////////////////////////////
   assign scl_oe_out = s.scl_oe;
   assign sda_oe_out = s.sda_oe;
   assign eng.done = s.done;
   assign eng.rx_byte = s.rx[8:1];
   assign eng.ack = !s.rx[0];
   assign eng.busy = (s.st != E_IDLE);
endmodule // blim_bit_engine

// ---- hw/blim_top.sv ----
// Operation
// - Boot loader and processor share one port
// - Port acts as bus master only
// - Boot reads identity bytes then program data
// - Boot load only after power-on reset
// - Processor held in reset during boot
// - Boot writes only code and scratch ranges
// - Host command reads or writes RAM
// - Host access only while processor held
// - Host access limited to both RAM ranges
// - Processor drives bus via control/data registers
`timescale 1ns/1ps
`include "blim_cfg.svh"
module blim_top #(
   parameter int QTR_CYC = `BLIM_QTR_CYC
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic por_in,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe_out,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   output logic cpu_reset_out,
   input wire logic host_cpu_hold_in,
   input wire logic host_req_in,
   input wire logic host_we_in,
   input wire logic [15:0] host_addr_in,
   input wire logic [7:0] host_wdata_in,
   output logic host_ack_out,
   output logic host_err_out,
   output logic [7:0] host_rdata_out,
   output logic ram_we_out,
   output logic ram_re_out,
   output logic [15:0] ram_addr_out,
   output logic [7:0] ram_wdata_out,
   input wire logic [7:0] ram_rdata_in,
   input wire logic cpu_ctl_wr_in,
   input wire logic cpu_dat_wr_in,
   input wire logic cpu_dat_rd_in,
   input wire logic [7:0] cpu_wdata_in,
   output logic [7:0] serial_bus_control_reg_out,
   output logic [7:0] serial_bus_byte_reg_out,
   output logic [47:0] usb_identity_words_out,
   output logic [7:0] boot_config_out,
   output logic boot_done_out
);
   import blim_pkg::*;
   blim_eng_if eng_bus();
   blim_top_state_t s, s_next;
   logic issue;
   blim_cmd_t icmd;
   logic [7:0] itx;
   logic inack;
   logic fin;
   logic [7:0] rx;
   logic boot_ok;
   ////////////////////////////////////////////////////////////////////////////////
   blim_bit_engine #(
      .QTR_CYC(QTR_CYC)
   ) u_engine (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .eng(eng_bus),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .scl_oe_out(scl_oe_out),
      .sda_oe_out(sda_oe_out)
   );
   assign eng_bus.cmd_valid = s.cmd_valid;
   assign eng_bus.cmd = s.cmd;
   assign eng_bus.tx_byte = s.tx;
   assign eng_bus.nack = s.nack;
   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_next = s;
      issue = 1'b0;
      icmd = CMD_READ;
      itx = 8'h00;
      inack = 1'b0;
      fin = s.wait_e && eng_bus.done;
      rx = eng_bus.rx_byte;
      boot_ok = 1'b0;
      s_next.cmd_valid = 1'b0;
      s_next.ram_we = 1'b0;
      s_next.ram_re = 1'b0;
      s_next.h_ack = 1'b0;
      s_next.hprev = host_cpu_hold_in;
      if (s.hprev && !host_cpu_hold_in && s.boot_st == B_RUN) begin
         s_next.hold = 1'b0;
      end
      // Processor register accesses
      if (cpu_ctl_wr_in) begin
         s_next.c_start = s.c_start | cpu_wdata_in[`BLIM_CTL_START_BIT];
         s_next.c_stop = s.c_stop | cpu_wdata_in[`BLIM_CTL_STOP_BIT];
         s_next.c_last = cpu_wdata_in[`BLIM_CTL_LAST_BIT];
      end
      if (cpu_dat_wr_in) begin
         s_next.c_tx = cpu_wdata_in;
         s_next.c_wr = 1'b1;
         s_next.c_done = 1'b0;
      end
      if (cpu_dat_rd_in) begin
         s_next.c_done = 1'b0;
         s_next.c_rd = !s_next.c_stop;
      end
      // Boot sequencer, then run-time control
      unique case (s.boot_st)
         B_IDLE: begin
            s_next.two_b = 1'b1;
            if (s.por) begin
               s_next.boot_st = B_START;
            end else begin
               s_next.hold = 1'b0;
               s_next.boot_st = B_RUN;
            end
         end
         B_START, B_RSTART: begin
            issue = 1'b1;
            icmd = CMD_START;
            if (fin) begin
               s_next.boot_st = (s.boot_st == B_START) ? B_DEVW : B_DEVR;
            end
         end
         B_DEVW, B_DEVR: begin
            issue = 1'b1;
            icmd = CMD_WRITE;
            itx = {s.two_b ? `BLIM_EE_DEV_WIDE : `BLIM_EE_DEV_NARROW, s.boot_st == B_DEVR};
            if (fin) begin
               if (!eng_bus.ack) begin
                  s_next.stop_next = (s.two_b && s.boot_st == B_DEVW) ? END_RETRY : END_FAIL;
                  s_next.two_b = 1'b0;
                  s_next.boot_st = B_STOP;
               end else if (s.boot_st == B_DEVR) begin
                  s_next.boot_st = B_SIG;
               end else begin
                  s_next.boot_st = s.two_b ? B_AH : B_AL;
               end
            end
         end
         B_AH, B_AL: begin
            issue = 1'b1;
            icmd = CMD_WRITE;
            if (fin) begin
               s_next.boot_st = (s.boot_st == B_AH) ? B_AL : B_RSTART;
            end
         end
         B_SIG: begin
            issue = 1'b1;
            if (fin) begin
               s_next.cnt = 3'h0;
               s_next.load = (rx == `BLIM_SIG_LOAD);
               if (rx == `BLIM_SIG_LOAD || rx == `BLIM_SIG_ID_ONLY) begin
                  s_next.boot_st = B_ID;
               end else begin
                  s_next.stop_next = END_FAIL;
                  s_next.boot_st = B_DUMMY;
               end
            end
         end
         B_ID: begin
            issue = 1'b1;
            if (fin) begin
               s_next.idw = {s.idw[47:0], rx};
               s_next.cnt = s.cnt + 3'h1;
               if (s.cnt == `BLIM_ID_LAST) begin
                  s_next.cnt = 3'h0;
                  s_next.stop_next = END_OK;
                  s_next.boot_st = s.load ? B_HDR : B_DUMMY;
               end
            end
         end
         B_HDR: begin
            issue = 1'b1;
            if (fin) begin
               {s_next.len, s_next.addr} = {s.len[7:0], s.addr, rx};
               s_next.cnt = s.cnt + 3'h1;
               if (s.cnt == 3'h0 && rx[`BLIM_END_MARK_BIT]) begin
                  s_next.boot_st = B_DUMMY;
               end else if (s.cnt == `BLIM_HDR_LAST) begin
                  s_next.cnt = 3'h0;
                  s_next.boot_st = (s_next.len == 16'h0) ? B_HDR : B_DATA;
               end
            end
         end
         B_DATA: begin
            issue = 1'b1;
            if (fin) begin
               s_next.ram_we = blim_in_ram(s.addr);
               s_next.ram_addr = s.addr;
               s_next.ram_wdata = rx;
               s_next.addr = s.addr + 16'h1;
               s_next.len = s.len - 16'h1;
               if (s.len == 16'h1) begin
                  s_next.boot_st = B_HDR;
               end
            end
         end
         B_DUMMY: begin
            issue = 1'b1;
            inack = 1'b1;
            if (fin) begin
               s_next.boot_st = B_STOP;
            end
         end
         B_STOP: begin
            issue = 1'b1;
            icmd = CMD_STOP;
            if (fin) begin
               s_next.boot_st = (s.stop_next == END_RETRY) ? B_START : B_DONE;
            end
         end
         B_DONE: begin
            boot_ok = (s.stop_next == END_OK);
            if (boot_ok) begin
               s_next.hold = 1'b0;
            end
            s_next.boot_st = B_RUN;
         end
         B_RUN: begin
            if (s.c_start) begin
               issue = 1'b1;
               icmd = CMD_START;
            end else if (s.c_wr) begin
               issue = 1'b1;
               icmd = CMD_WRITE;
               itx = s.c_tx;
            end else if (s.c_rd) begin
               issue = 1'b1;
               inack = s.c_last;
            end else if (s.c_stop) begin
               issue = 1'b1;
               icmd = CMD_STOP;
            end
            if (fin && (s.c_op == CMD_WRITE || s.c_op == CMD_READ)) begin
               s_next.c_done = 1'b1;
               s_next.c_ack = eng_bus.ack;
               if (s.c_op == CMD_READ) begin
                  s_next.c_rx = rx;
               end
            end
         end
         default: begin
            s_next.stop_next = END_FAIL;
            s_next.boot_st = B_DONE;
         end
      endcase
      // One engine, one owner at a time
      if (fin) begin
         s_next.wait_e = 1'b0;
      end
      if (issue && !s.wait_e && !eng_bus.busy) begin
         s_next.cmd_valid = 1'b1;
         s_next.cmd = icmd;
         s_next.tx = itx;
         s_next.nack = inack;
         s_next.wait_e = 1'b1;
         s_next.c_op = icmd;
         if (s.boot_st == B_RUN) begin
            unique case (icmd)
               CMD_START: s_next.c_start = cpu_ctl_wr_in && cpu_wdata_in[`BLIM_CTL_START_BIT];
               CMD_WRITE: s_next.c_wr = cpu_dat_wr_in;
               CMD_READ: s_next.c_rd = cpu_dat_rd_in && !s_next.c_stop;
               CMD_STOP: s_next.c_stop = cpu_ctl_wr_in && cpu_wdata_in[`BLIM_CTL_STOP_BIT];
            endcase
         end
      end
      // Host RAM access
      unique case (s.h_ph)
         2'h0: begin
            if (host_req_in) begin
               if (s.cpu_rst && s.boot_st == B_RUN && blim_in_ram(host_addr_in)) begin
                  s_next.ram_we = host_we_in;
                  s_next.ram_re = !host_we_in;
                  s_next.ram_addr = host_addr_in;
                  s_next.ram_wdata = host_wdata_in;
                  s_next.h_ph = 2'h1;
               end else begin
                  s_next.h_ack = 1'b1;
                  s_next.h_err = 1'b1;
               end
            end
         end
         2'h1: s_next.h_ph = 2'h2;
         2'h2: begin
            s_next.h_rdata = ram_rdata_in;
            s_next.h_ack = 1'b1;
            s_next.h_err = 1'b0;
            s_next.h_ph = 2'h0;
         end
         default: s_next.h_ph = 2'h0;
      endcase
      s_next.cpu_rst = s_next.hold | host_cpu_hold_in;
      s_next.ctl_view = 8'h00;
      s_next.ctl_view[`BLIM_CTL_START_BIT] = s_next.c_start;
      s_next.ctl_view[`BLIM_CTL_STOP_BIT] = s_next.c_stop;
      s_next.ctl_view[`BLIM_CTL_LAST_BIT] = s_next.c_last;
      s_next.ctl_view[`BLIM_CTL_BUSY_BIT] = s_next.wait_e;
      s_next.ctl_view[`BLIM_CTL_ACK_BIT] = s_next.c_ack;
      s_next.ctl_view[`BLIM_CTL_DONE_BIT] = s_next.c_done;
      s_next.pin_lvl = 1'b0;
      s_next.boot_done = (s_next.boot_st == B_RUN);
      if (!rst_b_in) begin
         s_next = '0;
         s_next.boot_st = B_IDLE;
         s_next.hold = 1'b1;
         s_next.cpu_rst = 1'b1;
         s_next.por = por_in;
      end
   end
   always_ff @(posedge clk_in) begin
      s <= s_next;
   end
   ////////////////////////////////////////////////////////////////////////////////
   assign scl_out = s.pin_lvl;
   assign sda_out = s.pin_lvl;
   assign cpu_reset_out = s.cpu_rst;
   assign host_ack_out = s.h_ack;
   assign host_err_out = s.h_err;
   assign host_rdata_out = s.h_rdata;
   assign ram_we_out = s.ram_we;
   assign ram_re_out = s.ram_re;
   assign ram_addr_out = s.ram_addr;
   assign ram_wdata_out = s.ram_wdata;
   assign serial_bus_control_reg_out = s.ctl_view;
   assign serial_bus_byte_reg_out = s.c_rx;
   assign usb_identity_words_out = s.idw[55:8];
   assign boot_config_out = s.idw[7:0];
   assign boot_done_out = s.boot_done;
endmodule // blim_top

// ---- dv/blim_props.sv ----
`timescale 1ns/1ps
module blim_props (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic por_in,
   input wire logic scl_out,
   input wire logic scl_oe_out,
   input wire logic sda_out,
   input wire logic sda_oe_out,
   input wire logic cpu_reset_out,
   input wire logic host_cpu_hold_in,
   input wire logic host_req_in,
   input wire logic host_we_in,
   input wire logic [15:0] host_addr_in,
   input wire logic [7:0] host_wdata_in,
   input wire logic host_ack_out,
   input wire logic host_err_out,
   input wire logic [7:0] host_rdata_out,
   input wire logic ram_we_out,
   input wire logic ram_re_out,
   input wire logic [15:0] ram_addr_out,
   input wire logic [7:0] ram_wdata_out,
   input wire logic [7:0] ram_rdata_in,
   input wire logic cpu_dat_wr_in,
   input wire logic [7:0] serial_bus_control_reg_out,
   input wire logic boot_done_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_b_in);
   function automatic logic in_rng(input logic [15:0] a);
      return a <= 16'h3fff || (a >= 16'he000 && a <= 16'he1ff);
   endfunction
   ////////////////////////////////////////
   sequence s_start;
      sda_oe_out && !scl_oe_out;
   endsequence
   sequence s_good_ack;
      host_ack_out && !host_err_out;
   endsequence
   sequence s_new_req;
      host_req_in && !$past(host_req_in) && !$past(host_req_in, 2) && boot_done_out;
   endsequence
   ////////////////////////////////////////
   a_pins_pull_only: assert property (!scl_out && !sda_out)
      else $error("serial pin driven high");
   a_boot_hold: assert property (!boot_done_out |-> cpu_reset_out)
      else $error("processor released during boot");
   a_ram_range: assert property (ram_we_out || ram_re_out |-> in_rng(ram_addr_out))
      else $error("ram access outside ranges");
   a_ram_held: assert property (ram_we_out |-> cpu_reset_out)
      else $error("ram write while processor runs");
   a_host_write: assert property (s_new_req ##0 (host_we_in && cpu_reset_out && in_rng(host_addr_in)) |=>
      ram_we_out && ram_addr_out == $past(host_addr_in) && ram_wdata_out == $past(host_wdata_in) ##2 s_good_ack)
      else $error("host write path wrong");
   a_host_read: assert property (ram_re_out && boot_done_out |-> ##2 s_good_ack ##0
      host_rdata_out == $past(ram_rdata_in)) else $error("host read path wrong");
   a_host_refuse: assert property (s_new_req ##0 (!cpu_reset_out || !in_rng(host_addr_in)) |=>
      host_ack_out && host_err_out) else $error("host request not refused");
   a_por_boot: assert property ($rose(rst_b_in) && $past(por_in) |-> ##[1:20] s_start)
      else $error("no boot start after power-on reset");
   a_plain_reset: assert property ($rose(rst_b_in) && !$past(por_in) && !host_cpu_hold_in |->
      ##[1:3] !cpu_reset_out && boot_done_out) else $error("plain reset did not release processor");
   a_done_clear: assert property (cpu_dat_wr_in && boot_done_out |-> ##[1:2] !serial_bus_control_reg_out[0])
      else $error("done bit not cleared");
endmodule // blim_props
bind blim_top blim_props chk_u (.*);

// ---- dv/blim_ee_model.sv ----
`timescale 1ns/1ps
module blim_ee_model #(
   parameter logic [6:0] DEV = 7'h51
) (
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic present_in,
   output logic sda_oe_out
);
   logic [7:0] mem [0:255];
   logic [7:0] sh = 8'h00;
   logic [15:0] ptr = 16'h0000;
   logic act = 1'h0;
   logic rd = 1'h0;
   int bc = 0;
   int nb = 0;
   initial sda_oe_out = 1'h0;
   ////////////////////////////////////////
   // Start and stop framing
   always @(negedge sda_in) if (scl_in === 1'h1) begin
      act = present_in;
      rd = 1'h0;
      bc = 0;
      nb = 0;
   end
   always @(posedge sda_in) if (scl_in === 1'h1) act = 1'h0;
   // Bits sampled on rising clock, master nack ends a read
   always @(posedge scl_in) if (act) begin
      if (bc < 8) begin
         sh = {sh[6:0], sda_in};
         bc++;
      end else begin
         if (rd && sda_in) act = 1'h0;
         bc = 0;
      end
   end
   // Answers change only while clock low; released line floats high
   always @(negedge scl_in) begin
      logic d;
      d = 1'h0;
      if (act && bc == 8 && !rd) begin
         if (nb == 0) begin
            rd = sh[0];
            act = sh[7:1] == DEV;
         end else if (nb == 1) ptr[15:8] = sh;
         else ptr[7:0] = sh;
         d = act;
         nb++;
      end else if (act && rd && bc < 8) d = !mem[ptr[7:0]][7 - bc];
      else if (act && rd) ptr++;
      sda_oe_out = d;
   end
endmodule // blim_ee_model

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   import blim_pkg::*;
   logic clk_in = '0, rst_b_in = '0, por_in = '1, host_cpu_hold_in = '0, host_req_in = '0, host_we_in = '0;
   logic cpu_ctl_wr_in = '0, cpu_dat_wr_in = '0, cpu_dat_rd_in = '0, present = '1, ee_oe;
   logic [15:0] host_addr_in = 16'h0000, ram_addr_out;
   logic [7:0] host_wdata_in = 8'h00, ram_rdata_in = 8'h00, cpu_wdata_in = 8'h00;
   logic scl_out, scl_oe_out, sda_out, sda_oe_out, cpu_reset_out, host_ack_out, host_err_out;
   logic ram_we_out, ram_re_out, boot_done_out;
   logic [7:0] host_rdata_out, ram_wdata_out, serial_bus_control_reg_out, serial_bus_byte_reg_out, boot_config_out;
   logic [47:0] usb_identity_words_out;
   wire logic scl_in = !scl_oe_out;
   wire logic sda_in = !(sda_oe_out || ee_oe);
   logic [7:0] ram [0:65535];
   logic [7:0] img [0:27] = '{8'ha2, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77,
      8'h00, 8'h02, 8'h00, 8'h10, 8'h5a, 8'ha5, 8'h00, 8'h01, 8'he0, 8'h00, 8'h3c,
      8'h00, 8'h01, 8'h80, 8'h00, 8'h99, 8'h80, 8'h00, 8'h00, 8'h00};
   int fails = 0, compares = 0;
   blim_top #(.QTR_CYC(2)) dut_u (.*);
   blim_ee_model ee_u (.scl_in(scl_in), .sda_in(sda_in), .present_in(present), .sda_oe_out(ee_oe));
   always #5 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      if (ram_we_out) ram[ram_addr_out] <= ram_wdata_out;
      ram_rdata_in <= ram_re_out ? ram[ram_addr_out] : ~ram_rdata_in;
   end
   ////////////////////////////////////////
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic do_reset(input logic p);
      @(posedge clk_in);
      rst_b_in <= '0;
      por_in <= p;
      repeat (4) @(posedge clk_in);
      rst_b_in <= '1;
   endtask
   task automatic wait_boot();
      int n;
      n = 0;
      while (boot_done_out !== 1'h1 && n < 20000) begin
         @(negedge clk_in);
         n++;
      end
      chk(boot_done_out, 1);
   endtask
   task automatic host_op(input logic w, input logic [15:0] a, input logic [7:0] d, input logic e,
      input logic [7:0] r);
      int n;
      n = 0;
      @(posedge clk_in);
      host_req_in <= '1;
      host_we_in <= w;
      host_addr_in <= a;
      host_wdata_in <= d;
      @(posedge clk_in);
      host_req_in <= '0;
      while (host_ack_out !== 1'h1 && n < 8) begin
         @(negedge clk_in);
         n++;
      end
      chk(host_ack_out, 1);
      chk(host_err_out, e);
      if (!w && !e) chk(host_rdata_out, r);
   endtask
   task automatic cpu_op(input logic [1:0] k, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      cpu_ctl_wr_in <= k == 2'h0;
      cpu_dat_wr_in <= k == 2'h1;
      cpu_dat_rd_in <= k == 2'h2;
      cpu_wdata_in <= d;
      @(posedge clk_in);
      cpu_ctl_wr_in <= '0;
      cpu_dat_wr_in <= '0;
      cpu_dat_rd_in <= '0;
      if (k != 2'h0) begin
         repeat (2) @(negedge clk_in);
         while (serial_bus_control_reg_out[0] !== 1'h1 && n < 400) begin
            @(negedge clk_in);
            n++;
         end
         chk(serial_bus_control_reg_out[0], 1);
      end
   endtask
   ////////////////////////////////////////
   task automatic t_boot();
      do_reset('1);
      wait_boot();
      chk(usb_identity_words_out, 48'h112233445566);
      chk(boot_config_out, 8'h77);
      chk({ram[16'h0010], ram[16'h0011], ram[16'he000]}, 24'h5aa53c);
      $display("test boot done");
   endtask
   task automatic t_host();
      @(posedge clk_in) host_cpu_hold_in <= '1;
      host_op('1, 16'h3fff, 8'ha5, '0, 8'h00);
      host_op('1, 16'he1ff, 8'h5a, '0, 8'h00);
      host_op('0, 16'h3fff, 8'h00, '0, 8'ha5);
      host_op('0, 16'he1ff, 8'h00, '0, 8'h5a);
      host_op('0, 16'h0010, 8'h00, '0, 8'h5a);
      host_op('1, 16'h4000, 8'h11, '1, 8'h00);
      host_op('0, 16'hdfff, 8'h00, '1, 8'h00);
      host_op('1, 16'he200, 8'h11, '1, 8'h00);
      @(posedge clk_in) host_cpu_hold_in <= '0;
      repeat (4) @(posedge clk_in);
      host_op('0, 16'h0010, 8'h00, '1, 8'h00);
      $display("test host done");
   endtask
   task automatic t_bus();
      cpu_op(2'h0, 8'h80);
      cpu_op(2'h1, 8'h66);
      chk(serial_bus_control_reg_out[1], 0);
      cpu_op(2'h0, 8'h80);
      cpu_op(2'h1, 8'ha2);
      chk(serial_bus_control_reg_out[1:0], 2'h3);
      cpu_op(2'h1, 8'h00);
      cpu_op(2'h1, 8'h05);
      cpu_op(2'h0, 8'h80);
      cpu_op(2'h1, 8'ha3);
      cpu_op(2'h0, 8'h20);
      cpu_op(2'h2, 8'h00);
      chk(serial_bus_byte_reg_out, 8'h55);
      cpu_op(2'h0, 8'h40);
      repeat (300) @(negedge clk_in);
      chk({scl_oe_out, sda_oe_out}, 2'h0);
      $display("test bus done");
   endtask
   task automatic t_nonpor();
      int n;
      n = 0;
      do_reset('0);
      repeat (300) begin
         @(negedge clk_in);
         if (scl_oe_out || sda_oe_out) n++;
      end
      chk(48'(n), 0);
      chk({cpu_reset_out, boot_done_out}, 2'h1);
      $display("test plain reset done");
   endtask
   task automatic t_no_ee();
      @(posedge clk_in) present <= '0;
      do_reset('1);
      wait_boot();
      repeat (20) @(negedge clk_in);
      chk(cpu_reset_out, 1);
      host_op('1, 16'h0020, 8'h42, '0, 8'h00);
      chk(ram[16'h0020], 8'h42);
      @(posedge clk_in) host_cpu_hold_in <= '1;
      repeat (4) @(posedge clk_in);
      host_cpu_hold_in <= '0;
      repeat (4) @(negedge clk_in);
      chk(cpu_reset_out, 0);
      $display("test no device done");
   endtask
   ////////////////////////////////////////
   initial begin
      foreach (ee_u.mem[i]) ee_u.mem[i] = (i < 28) ? img[i] : 8'hff;
      t_boot();
      t_host();
      t_bus();
      t_nonpor();
      t_no_ee();
      stop_test();
   end
   initial begin
      #500000;
      fails++;
      stop_test();
   end
endmodule // tb_top
